// >>> include/clock_source_prescaler_params.svh
// offsets, field positions, codes, reset values and timing counts
// assumes byte-addressed apb with one 32-bit word per register
`ifndef CLOCK_SOURCE_PRESCALER_PARAMS_SVH
`define CLOCK_SOURCE_PRESCALER_PARAMS_SVH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define OFF_OSC_TRIM 12'h000
`define OFF_CLOCK_DIVIDER_CONTROL 12'h004
`define OFF_CLOCK_STATUS 12'h008
`define UNLOCK_BIT 7
`define UNLOCK_WORD 8'h80
`define TRIM_RESET 8'h00
`define DIV_SEL_RESET 4'h0
`define DIV_SEL_DIV8 4'h3
`define DIV_SEL_MAX 4'h8
// ----------------------------------------------------------------
// fuse codes (a fuse at 0 is programmed)
// ----------------------------------------------------------------
`define SRC_EXT_CLOCK 4'h0
`define SRC_RC_OSC 4'h2
`define SRC_LOWPOWER_OSC 4'h4
`define SUT_NONE 2'h0
`define SUT_SHORT 2'h1
`define SUT_LONG 2'h2
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RESET_DELAY_CK 16'd14
`define WAKE_DELAY_CK 16'd6
`define UNLOCK_WINDOW_CK 3'd4
`define SHORT_TIMEOUT_MS 4
`define LONG_TIMEOUT_MS 64
`define SHORT_TIMEOUT_TICKS 512
`define LONG_TIMEOUT_TICKS 8192
`endif

// >>> include/clock_source_prescaler_pkg.sv
// types shared by the clock source and prescaler block
// assumes nothing of its surroundings
package clock_source_prescaler_pkg;
  typedef enum logic [2:0] {
    ST_LOAD,
    ST_CK14,
    ST_TIMEOUT,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } startup_state_e;
  typedef logic [3:0] div_sel_t;
endpackage

// >>> verilog/clock_source_prescaler.sv
// clock source select, start-up sequencing, oscillator trim and
// system clock prescaler with an apb register slave.
// assumes i_clk_sys is the undivided selected source clock, the
// watchdog oscillator arrives as a one-cycle tick, fuses are static.
//
// Behaviour
// - fuses 0010 select internal rc oscillator
// - factory trim loaded into trim at reset
// - wake from power-down waits six cycles
// - reset delay 14 cycles plus fuse timeout
// - fuses 0000 select external clock input
// - fuses 0100 select low-power oscillator
// - reset timeout counted on watchdog oscillator
// - all four clocks divided by same factor
// - divider switch without glitch or overspeed
// - switch lands after old plus new period
// - counter on undivided clock, not readable
// - trim writes apply to oscillator immediately
// - trim bit seven selects oscillator range
// - low seven trim bits tune monotonically
// - select writes ignored unless unlocked
// - unlock set only with other bits zero
// - unlock clears after four cycles or write
// - rewriting unlock neither extends nor clears
// - divider bits six to four read zero
// - four-bit select writable at run time
// - codes zero to eight divide one..256
// - divide-by-eight fuse picks select reset value
//
// The register addresses and the APB slave port were decided locally.
`include "clock_source_prescaler_params.svh"
`timescale 1ns/10ps
`default_nettype none

module clock_source_prescaler #(
  parameter int P_SHORT_TIMEOUT_TICKS = `SHORT_TIMEOUT_TICKS,
  parameter int P_LONG_TIMEOUT_TICKS = `LONG_TIMEOUT_TICKS
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // fuses and factory data
  input wire logic [3:0] i_source_select_fuses,
  input wire logic [1:0] i_startup_delay_fuses,
  input wire logic i_initial_div_eight_fuse,
  input wire logic [7:0] i_factory_trim,
  // watchdog oscillator tick and sleep request
  input wire logic i_wdt_osc_tick,
  input wire logic i_power_down,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // source select and oscillator trim
  output logic o_sel_rc_osc,
  output logic o_sel_ext_clock,
  output logic o_sel_lowpower_osc,
  output logic o_trim_range_bit,
  output logic [6:0] o_trim_fine_bits,
  // execution release and divided clock enables
  output logic o_run_release,
  output logic o_core_clk_en,
  output logic o_peripheral_io_clk_en,
  output logic o_converter_clk_en,
  output logic o_program_memory_clk_en
);
  import clock_source_prescaler_pkg::*;

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  // reserved codes run at the slowest rate, never faster than asked
  function automatic logic [7:0] div_mask(input div_sel_t sel);
    logic [7:0] m;
    m = 8'hff;
    if (sel <= `DIV_SEL_MAX) begin
      m = 8'(({1'b0, 8'hff} >> (4'd8 - sel)) & 9'h0ff);
    end
    return m;
  endfunction

  function automatic logic [15:0] timeout_ticks(input logic [1:0] startup_delay_fuses);
    logic [15:0] t;
    t = 16'(P_LONG_TIMEOUT_TICKS);
    if (startup_delay_fuses == `SUT_NONE) begin
      t = 16'h0000;
    end else if (startup_delay_fuses == `SUT_SHORT) begin
      t = 16'(P_SHORT_TIMEOUT_TICKS);
    end
    return t;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  startup_state_e st_q;
  logic [15:0] st_cnt_q;
  logic [3:0] src_sel_q;
  logic [1:0] sut_q;
  logic div8_fuse_q;
  logic fuses_loaded_q;
  logic [7:0] trim_q;
  logic unlock_q;
  logic [2:0] unlock_cnt_q;
  div_sel_t div_sel_q;
  div_sel_t pending_sel_q;
  logic change_req_q;
  logic [7:0] ripple_q;
  logic tick_now;
  logic tick_q;
  logic running;
  logic acc;
  logic wr;
  logic mapped;
  logic trim_wr;
  logic div_wr;
  logic unlock_wr;
  logic sel_wr;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite && i_pstrb[0];
  assign mapped = (i_paddr == `OFF_OSC_TRIM) || (i_paddr == `OFF_CLOCK_DIVIDER_CONTROL) ||
                  (i_paddr == `OFF_CLOCK_STATUS);
  assign trim_wr = wr && (i_paddr == `OFF_OSC_TRIM);
  assign div_wr = wr && (i_paddr == `OFF_CLOCK_DIVIDER_CONTROL);
  assign unlock_wr = div_wr && (i_pwdata[7:0] == `UNLOCK_WORD);
  assign sel_wr = div_wr && !i_pwdata[`UNLOCK_BIT];
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !mapped;

  always_comb begin
    o_prdata = 32'h0000_0000;
    if (i_paddr == `OFF_OSC_TRIM) begin
      o_prdata = {24'h00_0000, trim_q};
    end else if (i_paddr == `OFF_CLOCK_DIVIDER_CONTROL) begin
      o_prdata = {24'h00_0000, unlock_q, 3'h0, pending_sel_q};
    end else if (i_paddr == `OFF_CLOCK_STATUS) begin
      o_prdata = {24'h00_0000, running, div8_fuse_q, sut_q, src_sel_q};
    end
  end

  // ----------------------------------------------------------------
  // fuse capture and source select
  // ----------------------------------------------------------------
  // caught once after release so a fuse change cannot move the clock
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      src_sel_q <= `SRC_RC_OSC;
      sut_q <= `SUT_LONG;
      div8_fuse_q <= 1'b0;
      fuses_loaded_q <= 1'b0;
    end else if (!fuses_loaded_q) begin
      src_sel_q <= i_source_select_fuses;
      sut_q <= i_startup_delay_fuses;
      div8_fuse_q <= i_initial_div_eight_fuse;
      fuses_loaded_q <= 1'b1;
    end
  end

  // unsupported codes fall back to the rc oscillator
  assign o_sel_ext_clock = (src_sel_q == `SRC_EXT_CLOCK);
  assign o_sel_lowpower_osc = (src_sel_q == `SRC_LOWPOWER_OSC);
  assign o_sel_rc_osc = !o_sel_ext_clock && !o_sel_lowpower_osc;

  // ----------------------------------------------------------------
  // start-up sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      st_q <= ST_LOAD;
      st_cnt_q <= 16'h0000;
    end else begin
      unique case (st_q)
        ST_LOAD: begin
          if (fuses_loaded_q) begin
            st_q <= ST_CK14;
          end
          st_cnt_q <= 16'h0000;
        end
        ST_CK14: begin
          st_cnt_q <= st_cnt_q + 16'h0001;
          if (st_cnt_q == `RESET_DELAY_CK - 16'h0001) begin
            st_cnt_q <= 16'h0000;
            st_q <= (timeout_ticks(sut_q) == 16'h0000) ? ST_RUN : ST_TIMEOUT;
          end
        end
        ST_TIMEOUT: begin
          if (i_wdt_osc_tick) begin
            st_cnt_q <= st_cnt_q + 16'h0001;
            if (st_cnt_q == timeout_ticks(sut_q) - 16'h0001) begin
              st_q <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (i_power_down) begin
            st_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!i_power_down) begin
            st_q <= ST_WAKE;
            st_cnt_q <= 16'h0000;
          end
        end
        ST_WAKE: begin
          st_cnt_q <= st_cnt_q + 16'h0001;
          if (st_cnt_q == `WAKE_DELAY_CK - 16'h0001) begin
            st_q <= ST_RUN;
          end
        end
      endcase
    end
  end

  assign running = (st_q == ST_RUN);
  assign o_run_release = running;

  // ----------------------------------------------------------------
  // oscillator trim
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      trim_q <= `TRIM_RESET;
    end else if (st_q == ST_LOAD) begin
      trim_q <= i_factory_trim;
    end else if (trim_wr) begin
      trim_q <= i_pwdata[7:0];
    end
  end

  // the oscillator is monotonic in the fine bits inside each range
  assign o_trim_range_bit = trim_q[7];
  assign o_trim_fine_bits = trim_q[6:0];

  // ----------------------------------------------------------------
  // change unlock window
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      unlock_q <= 1'b0;
      unlock_cnt_q <= 3'h0;
    end else if (unlock_q) begin
      unlock_cnt_q <= unlock_cnt_q + 3'h1;
      if (sel_wr || (unlock_cnt_q == `UNLOCK_WINDOW_CK - 3'h1)) begin
        unlock_q <= 1'b0;
      end
    end else if (unlock_wr) begin
      unlock_q <= 1'b1;
      unlock_cnt_q <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // division select
  // ----------------------------------------------------------------
  // the new select waits for the next old-rate edge, so the gap
  // between edges is never shorter than the shorter of the two periods
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pending_sel_q <= `DIV_SEL_RESET;
      div_sel_q <= `DIV_SEL_RESET;
      change_req_q <= 1'b0;
    end else if (st_q == ST_LOAD) begin
      pending_sel_q <= div8_fuse_q ? `DIV_SEL_RESET : `DIV_SEL_DIV8;
      div_sel_q <= div8_fuse_q ? `DIV_SEL_RESET : `DIV_SEL_DIV8;
    end else begin
      if (sel_wr && unlock_q) begin
        pending_sel_q <= i_pwdata[3:0];
        change_req_q <= 1'b1;
      end else if (change_req_q && tick_now) begin
        div_sel_q <= pending_sel_q;
        change_req_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // prescaler counter and clock enables
  // ----------------------------------------------------------------
  // counts every undivided edge; its value never reaches the bus
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      ripple_q <= 8'h00;
    end else if (change_req_q && tick_now && !(sel_wr && unlock_q)) begin
      ripple_q <= 8'h00;
    end else begin
      ripple_q <= ripple_q + 8'h01;
    end
  end

  assign tick_now = running && ((ripple_q & div_mask(div_sel_q)) == div_mask(div_sel_q));

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_now;
    end
  end

  assign o_core_clk_en = tick_q;
  assign o_peripheral_io_clk_en = tick_q;
  assign o_converter_clk_en = tick_q;
  assign o_program_memory_clk_en = tick_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_src_rc_select: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (fuses_loaded_q && src_sel_q == `SRC_RC_OSC) |-> (o_sel_rc_osc && !o_sel_ext_clock))
    else $error("rc oscillator not selected");

  a_src_ext_select: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (fuses_loaded_q && src_sel_q == `SRC_EXT_CLOCK) |-> (o_sel_ext_clock && !o_sel_rc_osc))
    else $error("external clock not selected");

  a_src_lp_select: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (src_sel_q == `SRC_LOWPOWER_OSC) |-> (o_sel_lowpower_osc && !o_sel_rc_osc))
    else $error("low-power oscillator not selected");

  a_fuse_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (fuses_loaded_q && $past(fuses_loaded_q)) |-> ($stable(src_sel_q) && $stable(sut_q)))
    else $error("fuse copy changed after capture");

  a_trim_factory_load: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == ST_LOAD) |=> (trim_q == $past(i_factory_trim)))
    else $error("factory trim not loaded");

  a_trim_apply: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (trim_wr && st_q != ST_LOAD)
      |=> ({o_trim_range_bit, o_trim_fine_bits} == $past(i_pwdata[7:0])))
    else $error("trim write not applied");

  a_reset_ck14: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == ST_LOAD && fuses_loaded_q)
      |=> (st_q == ST_CK14) ##13 (st_q == ST_CK14) ##1 (st_q != ST_CK14))
    else $error("reset delay not 14 cycles");

  a_wake_six: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == ST_SLEEP && !i_power_down) |=> (!o_run_release)[*6] ##1 o_run_release)
    else $error("wake delay not 6 cycles");

  a_unlock_window: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    $rose(unlock_q) |-> ##[1:4] !unlock_q)
    else $error("unlock window too long");

  a_unlock_full: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ($rose(unlock_q) ##0 (!sel_wr)[*3]) |-> unlock_q)
    else $error("unlock cleared early");

  a_locked_ignore: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (sel_wr && !unlock_q && st_q != ST_LOAD) |=> $stable(pending_sel_q))
    else $error("locked select write accepted");

  a_unlock_only_clean: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (div_wr && i_pwdata[7] && i_pwdata[6:0] != 7'h00 && !unlock_q) |=> !unlock_q)
    else $error("unlock set by unclean write");

  a_rsvd_zero: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (i_paddr == `OFF_CLOCK_DIVIDER_CONTROL) |-> (o_prdata[6:4] == 3'h0))
    else $error("reserved divider bits not zero");

  a_switch_on_edge: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q != ST_LOAD && $past(st_q) != ST_LOAD && $changed(div_sel_q)) |-> $past(tick_now))
    else $error("divider switched between edges");

  a_switch_div2: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (running && $past(running) && $changed(div_sel_q) && div_sel_q == 4'h1)
      |-> !tick_now ##1 tick_now)
    else $error("first divide-by-2 edge misplaced");

  a_div1_rate: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (running && div_sel_q == 4'h0 && !change_req_q) |=> o_core_clk_en)
    else $error("divide-by-1 missed an edge");

  a_div8_reset: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == ST_LOAD && fuses_loaded_q) |=> (div_sel_q == (div8_fuse_q ? 4'h0 : 4'h3)))
    else $error("wrong select after reset");

  a_en_together: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_core_clk_en |-> (o_peripheral_io_clk_en && o_converter_clk_en && $past(running)))
    else $error("clock enables disagree");

endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the clock source select, start-up and prescaler block
// assumes the design package and the register map header are on the include path
`include "clock_source_prescaler_params.svh"
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import clock_source_prescaler_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] src_f = `SRC_RC_OSC;
  logic [1:0] sut_f = `SUT_SHORT;
  logic div8_f = 1'b0;
  logic [7:0] ftrim = 8'h00;
  logic wdt_tick = 1'b0;
  logic power_down = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sel_rc, sel_ext, sel_lp, trim_range, run, en_core, en_io, en_conv, en_mem;
  logic [6:0] trim_fine;
  logic [1:0] tick_cnt = 2'h0;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 32'h6dcf;

  // short reset timeouts keep the run brief; bounds below derive from them
  clock_source_prescaler #(.P_SHORT_TIMEOUT_TICKS(4), .P_LONG_TIMEOUT_TICKS(8)) i_dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_source_select_fuses(src_f),
    .i_startup_delay_fuses(sut_f), .i_initial_div_eight_fuse(div8_f),
    .i_factory_trim(ftrim), .i_wdt_osc_tick(wdt_tick), .i_power_down(power_down),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_sel_rc_osc(sel_rc), .o_sel_ext_clock(sel_ext),
    .o_sel_lowpower_osc(sel_lp), .o_trim_range_bit(trim_range),
    .o_trim_fine_bits(trim_fine), .o_run_release(run), .o_core_clk_en(en_core),
    .o_peripheral_io_clk_en(en_io), .o_converter_clk_en(en_conv),
    .o_program_memory_clk_en(en_mem)
  );

  // ----------------------------------------------------------------
  // clock, watchdog tick every fourth cycle, timeout
  // ----------------------------------------------------------------
  initial begin
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys) begin
    tick_cnt <= tick_cnt + 2'h1;
    wdt_tick <= (tick_cnt == 2'h3);
  end

  always @(posedge i_clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      complete_run();
    end
  end

  // all four divided clocks must move together
  always @(posedge i_clk_sys) begin
    if (i_reset === 1'b0) begin
      check({29'h0, en_io, en_conv, en_mem}, {29'h0, {3{en_core}}});
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // rel low keeps psel up so the next call's setup cycle follows at once
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input bit rel, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    @(posedge i_clk_sys);
    while (pready !== 1'b1) @(posedge i_clk_sys);
    rd = prdata;
    err = pslverr;
    if (rel) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clk_sys);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit rel);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hf, rel, r, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input bit rel);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 4'h0, rel, r, e);
    check(r, exp);
  endtask

  function automatic int factor(input logic [3:0] c);
    return (c > `DIV_SEL_MAX) ? 256 : (1 << c);
  endfunction

  function automatic int ticks(input logic [1:0] s);
    return (s == `SUT_NONE) ? 0 : ((s == `SUT_SHORT) ? 4 : 8);
  endfunction

  // counts edges until the core enable is seen high
  task automatic next_pulse(output int n);
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n = n + 1;
    end while (en_core !== 1'b1 && n < 600);
  endtask

  task automatic boot(input logic [3:0] src, input logic [1:0] startup_delay_fuses, input logic dv8);
    int n;
    int t;
    logic rc;
    t = ticks(startup_delay_fuses);
    rc = (src != `SRC_EXT_CLOCK) && (src != `SRC_LOWPOWER_OSC);
    i_reset <= 1'b1;
    src_f <= src;
    sut_f <= startup_delay_fuses;
    div8_f <= dv8;
    ftrim <= 8'($random(seed));
    repeat (6) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n = n + 1;
    end while (run !== 1'b1 && n < 200);
    check(32'(n >= 16 + ((t > 0) ? (t - 1) * 4 : 0)), 32'h1);
    check(32'(n <= 16 + t * 4 + 8), 32'h1);
    check({29'h0, sel_ext, sel_rc, sel_lp}, {29'h0, src == `SRC_EXT_CLOCK, rc,
          src == `SRC_LOWPOWER_OSC});
    rdc(`OFF_OSC_TRIM, {24'h0, ftrim}, 1'b1);
    rdc(`OFF_CLOCK_DIVIDER_CONTROL, dv8 ? 32'h0 : 32'h3, 1'b1);
    src_f <= ~src;
    sut_f <= ~startup_delay_fuses;
    rdc(`OFF_CLOCK_STATUS, {24'h0, 1'b1, dv8, startup_delay_fuses, src}, 1'b1);
    check({29'h0, sel_ext, sel_rc, sel_lp}, {29'h0, src == `SRC_EXT_CLOCK, rc,
          src == `SRC_LOWPOWER_OSC});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] trims [4];
    logic [3:0] order [10];
    logic [31:0] r;
    logic e;
    logic [3:0] cur;
    logic [3:0] c;
    int n;
    trims = '{8'h7f, 8'h80, 8'h00, 8'h00};
    order = '{4'h0, 4'h8, 4'h1, 4'h7, 4'h2, 4'h6, 4'h4, 4'h5, 4'h3, 4'h9};
    boot(`SRC_RC_OSC, `SUT_SHORT, 1'b0);
    trims[2] = 8'($random(seed));
    trims[3] = 8'($random(seed));
    foreach (trims[i]) begin
      wr(`OFF_OSC_TRIM, {24'h0, trims[i]}, 1'b1);
      check({24'h0, trim_range, trim_fine}, {24'h0, trims[i]});
      rdc(`OFF_OSC_TRIM, {24'h0, trims[i]}, 1'b1);
    end
    // a write with the low byte strobe off leaves the trim alone
    apb(1'b1, `OFF_OSC_TRIM, 32'h0000_005a, 4'h0, 1'b1, r, e);
    rdc(`OFF_OSC_TRIM, {24'h0, trims[3]}, 1'b1);
    apb(1'b0, 12'h00c, 32'h0, 4'h0, 1'b1, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    // locked select write, then unlock with stray bits, then select again
    wr(`OFF_CLOCK_DIVIDER_CONTROL, 32'h1, 1'b1);
    rdc(`OFF_CLOCK_DIVIDER_CONTROL, 32'h3, 1'b1);
    wr(`OFF_CLOCK_DIVIDER_CONTROL, 32'h81, 1'b1);
    wr(`OFF_CLOCK_DIVIDER_CONTROL, 32'h1, 1'b1);
    rdc(`OFF_CLOCK_DIVIDER_CONTROL, 32'h3, 1'b1);
    // second unlock inside the window must not restart it
    wr(`OFF_CLOCK_DIVIDER_CONTROL, 32'h80, 1'b0);
    wr(`OFF_CLOCK_DIVIDER_CONTROL, 32'h80, 1'b0);
    rdc(`OFF_CLOCK_DIVIDER_CONTROL, 32'h83, 1'b0);
    wr(`OFF_CLOCK_DIVIDER_CONTROL, 32'h1, 1'b1);
    rdc(`OFF_CLOCK_DIVIDER_CONTROL, 32'h3, 1'b1);
    // unlock lapses after four cycles
    wr(`OFF_CLOCK_DIVIDER_CONTROL, 32'h80, 1'b1);
    repeat (4) @(posedge i_clk_sys);
    wr(`OFF_CLOCK_DIVIDER_CONTROL, 32'h2, 1'b1);
    rdc(`OFF_CLOCK_DIVIDER_CONTROL, 32'h3, 1'b1);
    cur = 4'h3;
    foreach (order[i]) begin
      c = (i == 9) ? 4'h9 + 4'(($random(seed) & 32'h7) % 7) : order[i];
      wr(`OFF_CLOCK_DIVIDER_CONTROL, 32'h80, 1'b0);
      wr(`OFF_CLOCK_DIVIDER_CONTROL, {25'h0, 3'($random(seed)), c}, 1'b1);
      next_pulse(n);
      check(32'(n <= factor(cur) + 4), 32'h1);
      next_pulse(n);
      check(32'(n), 32'(factor(c)));
      next_pulse(n);
      check(32'(n), 32'(factor(c)));
      rdc(`OFF_CLOCK_DIVIDER_CONTROL, {28'h0, c}, 1'b1);
      cur = c;
    end
    // power-down, then wake
    power_down <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    check({31'h0, run}, 32'h0);
    power_down <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n = n + 1;
    end while (run !== 1'b1 && n < 50);
    check(32'(n >= 6 && n <= 8), 32'h1);
    boot(`SRC_LOWPOWER_OSC, `SUT_NONE, 1'b1);
    boot(`SRC_EXT_CLOCK, `SUT_LONG, 1'b1);
    boot(4'h6, 2'h3, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
